// [hw/fmpc_config.sv]
`timescale 1ns/10ps
// Functional notes
// - One byte register at offset 0x05 holds fan modes and pin selection.
// - Bit 7 set routes the reset-output function to the shared pin.
// - Bits 6 and 7 both clear leave the shared pin disabled.
// - Over-temperature drives the pin only with bit 6 set, bit 7 clear.
// - Fan 2 level mode: bit 4 set active-low, clear active-high.
// - Fan 1 level mode: bit 2 set active-low, clear active-high.
// - Bit 1 selects fan 2 level mode, else pulse count; resets 0.
// - Bit 0 selects fan 1 level mode, else pulse count; resets 0.
module fmpc_config
   import fmpc_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire fmpc_req_t req,
   input wire logic req_valid,
   output logic [7:0] rdata,
   output logic ack,
   input wire logic fan1_input,
   input wire logic fan2_input,
   input wire logic reset_request,
   input wire logic overtemp_event,
   output logic shared_pin_out,
   output logic shared_pin_oe,
   output fmpc_fan_cfg_t fan1_cfg,
   output fmpc_fan_cfg_t fan2_cfg,
   output logic fan1_alarm,
   output logic fan2_alarm,
   output fmpc_pin_sel_t pin_sel
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync;
   logic rst_n;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ------------------------------------------------------------
   // Configuration register
   // ------------------------------------------------------------
   logic [7:0] cfg_reg;
   logic [7:0] next_cfg_reg;
   logic [7:0] next_rdata;
   logic hit;

   assign hit = req_valid && (req.addr == FMPC_CFG_OFFSET);
   assign next_cfg_reg = (hit && req.wr) ? req.wdata : cfg_reg;
   // Unmapped reads return zero so the bus engine never sees stale data.
   assign next_rdata = (hit && !req.wr) ? cfg_reg : 8'h00;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= FMPC_CFG_RESET;
         rdata <= 8'h00;
         ack <= 1'b0;
      end else begin
         cfg_reg <= next_cfg_reg;
         rdata <= next_rdata;
         ack <= req_valid;
      end
   end

   // ------------------------------------------------------------
   // Shared output pin
   // ------------------------------------------------------------
   logic rst_en;
   logic os_en;
   fmpc_pin_sel_t next_pin_sel;
   logic next_pin_out;
   logic next_pin_oe;

   assign rst_en = cfg_reg[FMPC_BIT_RESET_OUT];
   assign os_en = cfg_reg[FMPC_BIT_OVERTEMP];
   assign next_pin_sel = rst_en ? FMPC_PIN_RESET :
                         os_en ? FMPC_PIN_OVERTEMP : FMPC_PIN_OFF;
   // Open drain: only a low is driven, and only by the selected function.
   assign next_pin_oe = (next_pin_sel == FMPC_PIN_RESET) ? reset_request :
                        (next_pin_sel == FMPC_PIN_OVERTEMP) ? overtemp_event : 1'b0;
   assign next_pin_out = 1'b0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sel <= FMPC_PIN_OFF;
         shared_pin_oe <= 1'b0;
         shared_pin_out <= 1'b0;
      end else begin
         pin_sel <= next_pin_sel;
         shared_pin_oe <= next_pin_oe;
         shared_pin_out <= next_pin_out;
      end
   end

   // ------------------------------------------------------------
   // Fan inputs
   // ------------------------------------------------------------
   fmpc_fan_cfg_t f1_cfg;
   fmpc_fan_cfg_t f2_cfg;
   logic f1_alarm;
   logic f2_alarm;

   fmpc_fan_decode u_fan1 (
      .mode_bit(cfg_reg[FMPC_BIT_FAN1_MODE]),
      .field(cfg_reg[FMPC_FAN1_DIV_LSB +: 2]),
      .fan_in(fan1_input),
      .cfg(f1_cfg),
      .level_alarm(f1_alarm)
   );

   fmpc_fan_decode u_fan2 (
      .mode_bit(cfg_reg[FMPC_BIT_FAN2_MODE]),
      .field(cfg_reg[FMPC_FAN2_DIV_LSB +: 2]),
      .fan_in(fan2_input),
      .cfg(f2_cfg),
      .level_alarm(f2_alarm)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fan1_cfg <= '0;
         fan2_cfg <= '0;
         fan1_alarm <= 1'b0;
         fan2_alarm <= 1'b0;
      end else begin
         fan1_cfg <= f1_cfg;
         fan2_cfg <= f2_cfg;
         fan1_alarm <= f1_alarm;
         fan2_alarm <= f2_alarm;
      end
   end

endmodule

// [hw/fmpc_fan_decode.sv]
`timescale 1ns/10ps
module fmpc_fan_decode
   import fmpc_pkg::*;
(
   input wire logic mode_bit,
   input wire logic [1:0] field,
   input wire logic fan_in,
   output fmpc_fan_cfg_t cfg,
   output logic level_alarm
);

   // In level mode the divisor field's low bit doubles as polarity.
   assign cfg.level_mode = mode_bit;
   assign cfg.active_low = field[0];
   assign cfg.div_code = field;
   assign cfg.divide_by = 4'h1 << field;
   assign level_alarm = mode_bit & (fan_in ^ field[0]);

endmodule

// [hw/fmpc_pkg.sv]
package fmpc_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] FMPC_CFG_OFFSET = 8'h05;
   localparam logic [7:0] FMPC_CFG_RESET = 8'h14;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int FMPC_BIT_RESET_OUT = 7;
   localparam int FMPC_BIT_OVERTEMP = 6;
   localparam int FMPC_FAN2_DIV_LSB = 4;
   localparam int FMPC_FAN1_DIV_LSB = 2;
   localparam int FMPC_BIT_FAN2_MODE = 1;
   localparam int FMPC_BIT_FAN1_MODE = 0;

   typedef enum logic [1:0] {
      FMPC_PIN_OFF = 2'b00,
      FMPC_PIN_OVERTEMP = 2'b01,
      FMPC_PIN_RESET = 2'b10
   } fmpc_pin_sel_t;

   // Register access request from the serial bus engine.
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fmpc_req_t;

   // Decoded settings of one fan input.
   typedef struct packed {
      logic level_mode;
      logic active_low;
      logic [1:0] div_code;
      logic [3:0] divide_by;
   } fmpc_fan_cfg_t;

endpackage

// [tb/fmpc_config_tb_top.sv]
`timescale 1ns/10ps
module fmpc_config_tb_top;
   import fmpc_pkg::*;
   logic core_clk = 0, reset_n = 0, fan1_input = 0, fan2_input = 0, reset_request = 0;
   logic overtemp_event = 0, req_valid, ack, shared_pin_out, shared_pin_oe, fan1_alarm, fan2_alarm;
   logic [7:0] rdata, q, d;
   fmpc_req_t req;
   fmpc_fan_cfg_t fan1_cfg, fan2_cfg;
   fmpc_pin_sel_t pin_sel;
   int num_errors = 0, tests_run = 0;
   always #4 core_clk = ~core_clk;
   fmpc_config dut_u (.core_clk, .reset_n, .req, .req_valid, .rdata, .ack, .fan1_input,
      .fan2_input, .reset_request, .overtemp_event, .shared_pin_out, .shared_pin_oe,
      .fan1_cfg, .fan2_cfg, .fan1_alarm, .fan2_alarm, .pin_sel);
   fmpc_host host_u (.core_clk, .ack, .rdata, .req, .req_valid);
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task end_of_test;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      host_u.xfer(1'b1, 8'h06, 8'hff, q);
      host_u.xfer(1'b0, 8'h05, 8'h00, q);
      chk("reset", 8'h14, q);
      host_u.xfer(1'b0, 8'h06, 8'h00, q);
      chk("unmapped", 8'h00, q);
      // Every register value is tried, with all four input combinations each.
      for (int i = 0; i < 256; i++) begin
         d = 8'(i);
         host_u.xfer(1'b1, 8'h05, d, q);
         host_u.xfer(1'b0, 8'h05, 8'h00, q);
         chk("reg", d, q);
         chk("div1", 8'(4'h1 << d[3:2]), 8'(fan1_cfg.divide_by));
         chk("div2", 8'(4'h1 << d[5:4]), 8'(fan2_cfg.divide_by));
         for (int v = 0; v < 4; v++) begin
            @(posedge core_clk);
            {fan1_input, reset_request, fan2_input, overtemp_event} <= {v[0], v[0], v[1], v[1]};
            repeat (2) @(posedge core_clk);
            #1;
            chk("pin", 8'(d[7] ? v[0] : d[6] & v[1]), 8'(shared_pin_oe));
            chk("alarm1", 8'(d[0] & (v[0] ^ d[2])), 8'(fan1_alarm));
            chk("alarm2", 8'(d[1] & (v[1] ^ d[4])), 8'(fan2_alarm));
         end
      end
      end_of_test();
   end
endmodule

// [tb/fmpc_host.sv]
`timescale 1ns/10ps
module fmpc_host
   import fmpc_pkg::*;
(
   input wire logic core_clk,
   input wire logic ack,
   input wire logic [7:0] rdata,
   output fmpc_req_t req,
   output logic req_valid
);
   initial begin
      req = '0;
      req_valid = 1'b0;
   end
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge core_clk);
      req <= '{wr, a, d};
      req_valid <= 1'b1;
      @(posedge core_clk);
      // A released request is scrambled so that nothing relies on stale fields.
      req <= ~req;
      req_valid <= 1'b0;
      // The answer stands for the one cycle after the taking edge only.
      #1;
      q = ack ? rdata : 8'hee;
   endtask
endmodule

// [tb/fmpc_sva.sv]
`timescale 1ns/10ps
module fmpc_sva
   import fmpc_pkg::*;
(
   input wire logic core_clk, reset_n, req_valid, ack, fan1_input, fan2_input,
   input wire logic reset_request, overtemp_event, shared_pin_oe, fan1_alarm, fan2_alarm,
   input wire fmpc_req_t req,
   input wire logic [7:0] rdata,
   input wire fmpc_fan_cfg_t fan1_cfg, fan2_cfg,
   input wire fmpc_pin_sel_t pin_sel
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_wr;
      req_valid && req.wr && req.addr == FMPC_CFG_OFFSET;
   endsequence
   property p_k; req_valid |=> ack; endproperty
   a_k: assert property (p_k) else $error("no ack");
   property p_z; req_valid && req.addr != FMPC_CFG_OFFSET |=> rdata == 8'h00; endproperty
   a_z: assert property (p_z) else $error("unmapped read data");
   property p_off; pin_sel == FMPC_PIN_OFF |-> !shared_pin_oe; endproperty
   a_off: assert property (p_off) else $error("pin driven while off");
   property p_rst; pin_sel == FMPC_PIN_RESET |-> shared_pin_oe == $past(reset_request); endproperty
   a_rst: assert property (p_rst) else $error("reset pin");
   property p_ot; pin_sel == FMPC_PIN_OVERTEMP |-> shared_pin_oe == $past(overtemp_event); endproperty
   a_ot: assert property (p_ot) else $error("overtemp pin");
   property p_a1; fan1_alarm == (fan1_cfg.level_mode && $past(fan1_input) != fan1_cfg.div_code[0]); endproperty
   a_a1: assert property (p_a1) else $error("fan1 alarm");
   property p_a2; fan2_alarm == (fan2_cfg.level_mode && $past(fan2_input) != fan2_cfg.div_code[0]); endproperty
   a_a2: assert property (p_a2) else $error("fan2 alarm");
   property p_div; s_wr |-> ##2 fan1_cfg.divide_by == 4'h1 << fan1_cfg.div_code; endproperty
   a_div: assert property (p_div) else $error("fan1 divide");
endmodule
bind fmpc_config fmpc_sva chk_u (.core_clk, .reset_n, .req_valid, .ack, .fan1_input, .fan2_input,
   .reset_request, .overtemp_event, .shared_pin_oe, .fan1_alarm, .fan2_alarm, .req, .rdata,
   .fan1_cfg, .fan2_cfg, .pin_sel);
